// ===== verilog/sdp_port.sv
// sdram port of the external memory interface with bus release handshake
// assumes sdram devices clocked by memory_bus_clock and a master that asks for the bus
`timescale 1ns/1ps
module sdp_port
  import sdp_pkg::*;
#(
  parameter int ADDR_W = SDP_ADDR_W,
  parameter int DATA_W = SDP_DATA_W,
  parameter int BURST_W = SDP_BURST_DATA_W
) (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes core and link state when low; the synchronisers run on
  input wire logic req_valid, // access request
  output logic req_ready, // block can take a request
  input wire logic [2:0] req_op, // operation
  input wire logic [1:0] req_burst, // burst order
  input wire logic [7:0] req_order, // random order, 2 bits per word
  input wire logic [ADDR_W-1:0] req_addr, // row, column or mode value
  input wire logic [1:0] req_space, // select line to use
  input wire logic [SDP_LANES-1:0] req_byte_en_n, // write lanes, active low
  input wire logic [BURST_W-1:0] req_wdata, // four write words, word 0 low
  output logic resp_valid, // access finished, one cycle
  output logic [BURST_W-1:0] resp_rdata, // four read words, word 0 low
  output logic bus_away, // bus currently granted away
  input wire logic release_inhibit, // one postpones any hold not yet taken; a hold already taken still gets its grant
  input wire logic memory_bus_clock, // memory clock, paces the pins
  input wire logic bus_release_req_n, // release request pin
  output logic bus_release_grant_n, // release grant pin, active low
  output logic ext_bus_oe, // drive enable for selects, lanes, address, strobes
  output logic [SDP_SPACES-1:0] space_select_n, // space selects
  output logic [SDP_LANES-1:0] byte_lane_n, // byte lanes
  output logic [ADDR_W-1:0] ext_address, // word address
  output logic [DATA_W-1:0] ext_data_bus_out, // data driven out
  output logic ext_data_bus_oe, // data drive enable
  input wire logic [DATA_W-1:0] ext_data_bus_in, // data from the pins
  output logic read_col_shared_pin, // column strobe
  output logic write_shared_pin, // write strobe
  output logic output_row_shared_pin // row strobe
);

  // ==========================================================
  // core domain state
  typedef struct packed {
    logic busy;
    logic req_tgl;
    logic done_seen;
    logic ready;
    logic resp_valid;
    logic away;
    // request fields below are read by the link side while busy is high
    logic [2:0] op;
    logic [1:0] bt;
    logic [7:0] ord;
    logic [ADDR_W-1:0] addr;
    logic [1:0] space;
    logic [SDP_LANES-1:0] ben_n;
    logic [BURST_W-1:0] wdata;
    logic [BURST_W-1:0] rdata;
  } sdp_core_s;

  // ==========================================================
  // link domain state
  typedef struct packed {
    sdp_link_state_e state;
    logic [SDP_STEP_W-1:0] step;
    logic req_seen;
    logic done_tgl;
    logic drive;
    logic grant_n;
    logic data_oe;
    // the fields below are the pin flops, then the captured read words
    logic [SDP_SPACES-1:0] cs_n;
    logic [SDP_LANES-1:0] lane_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic [2:0] strobes;
    logic [BURST_W-1:0] rdata;
  } sdp_link_s;

  sdp_core_s core_reg;
  sdp_core_s core_next;
  sdp_link_s link_reg;
  sdp_link_s link_next;

  // ==========================================================
  // crossings
  logic [4:0] to_link_s;
  logic [1:0] to_core_s;
  logic l_rst_n;
  logic l_ce;
  logic l_req_tgl;
  logic l_inhibit;
  logic l_hold_n;
  logic c_done_tgl;
  logic c_grant_n;
  // only toggles and levels cross; request fields and read words wait still behind them

  sdp_sync #(.W(5)) u_link_sync (
    .clk(memory_bus_clock),
    .d({rst_n, ce, core_reg.req_tgl, release_inhibit, bus_release_req_n}),
    .q(to_link_s)
  );
  assign {l_rst_n, l_ce, l_req_tgl, l_inhibit, l_hold_n} = to_link_s;

  sdp_sync #(.W(2)) u_core_sync (
    .clk(core_clk),
    .d({link_reg.done_tgl, link_reg.grant_n}),
    .q(to_core_s)
  );
  assign {c_done_tgl, c_grant_n} = to_core_s;

  // ==========================================================
  // core side: takes a request, holds its fields stable for the link
  always_comb begin
    core_next = core_reg;
    core_next.resp_valid = 1'b0;
    core_next.away = ~c_grant_n;
    if (core_reg.ready && req_valid) begin
      core_next.busy = 1'b1;
      core_next.ready = 1'b0;
      core_next.req_tgl = ~core_reg.req_tgl;
      core_next.op = req_op;
      core_next.bt = req_burst;
      core_next.ord = req_order;
      core_next.addr = req_addr;
      core_next.space = req_space;
      core_next.ben_n = req_byte_en_n;
      core_next.wdata = req_wdata;
    end else if (core_reg.busy && (c_done_tgl != core_reg.done_seen)) begin
      // link data is stable until the next request is toggled in
      core_next.done_seen = c_done_tgl;
      core_next.busy = 1'b0;
      core_next.ready = 1'b1;
      core_next.resp_valid = 1'b1;
      core_next.rdata = link_reg.rdata;
    end
  end

  // ce freezes the core; the synchronisers run on so their levels never go stale
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      core_reg <= '0;
      core_reg.ready <= 1'b1;
    end else if (ce) begin
      core_reg <= core_next;
    end
  end

  // resp_rdata stays put until the next completion
  assign req_ready = core_reg.ready;
  assign resp_valid = core_reg.resp_valid;
  assign resp_rdata = core_reg.rdata;
  assign bus_away = core_reg.away;

  // ==========================================================
  // link side: sequencing of one access
  logic pending;
  logic col_cycle;
  logic [2:0] enc_strobes;
  logic [2:0] last_step;
  logic [SDP_COL_W-1:0] col_base;
  logic [SDP_COL_W-1:0] col_addr;
  logic [1:0] word_idx;
  logic [1:0] rd_idx;
  logic is_read;
  logic is_write;
  logic is_rw;
  logic rd_capture;
  logic release_due;
  logic hold_released;
  logic access_end;
  logic [SDP_STEP_W-1:0] rd_first_step;

  assign pending = (l_req_tgl != link_reg.req_seen);
  assign is_read = (core_reg.op == SDP_OP_READ);
  assign is_write = (core_reg.op == SDP_OP_WRITE);
  assign is_rw = is_read || is_write;
  assign col_base = core_reg.addr[SDP_COL_W-1:0];
  assign word_idx = link_reg.step[1:0];
  // pins lag the state by one clock, so the first read word is sampled one step
  // after the column latency has run from the step that issued the command
  assign rd_first_step = 3'(SDP_CAS_LAT + SDP_ONE_STEP);
  assign rd_idx = 2'(link_reg.step - rd_first_step);
  assign rd_capture = is_read && (link_reg.step >= rd_first_step);
  // a hold is taken only with the synchronised inhibit low; a hold already taken still gets its grant
  assign release_due = !l_hold_n && !l_inhibit;
  assign hold_released = l_hold_n;
  assign access_end = (link_reg.step == last_step);

  // a read ends on the step that samples its fourth word
  always_comb begin
    last_step = SDP_FIRST_STEP;
    if (is_read) begin
      last_step = 3'(SDP_READ_STEPS - SDP_ONE_STEP);
    end else if (is_write) begin
      last_step = 3'(SDP_WRITE_STEPS - SDP_ONE_STEP);
    end
  end

  // incrementing bursts use the device counter; others interrupt it each word
  always_comb begin
    col_cycle = 1'b0;
    col_addr = col_base;
    if (link_reg.step == SDP_FIRST_STEP) begin
      col_cycle = 1'b1;
    end else if (is_rw && (link_reg.step <= SDP_LAST_COL_STEP)) begin
      col_cycle = (core_reg.bt != SDP_BT_INCR);
    end
    // random order replaces the two low column bits, word by word
    case (core_reg.bt)
      SDP_BT_DECR: col_addr = SDP_COL_W'(col_base - SDP_COL_W'(link_reg.step));
      SDP_BT_RAND: col_addr = {col_base[SDP_COL_W-1:2], core_reg.ord[2 * word_idx +: 2]};
      default: col_addr = col_base;
    endcase
  end

  // the encoder is combinational; its result is registered in the pin flops
  sdp_cmd_enc u_cmd_enc (
    .op(core_reg.op),
    .col_cycle(col_cycle),
    .strobes(enc_strobes)
  );

  always_comb begin
    link_next = link_reg;
    case (link_reg.state)
      SDP_L_IDLE: begin
        // a hold and a new request in the same clock: the hold wins, the request waits
        if (release_due) begin
          // two sync edges already lie behind the request: float now
          link_next.drive = 1'b0;
          link_next.data_oe = 1'b0;
          link_next.state = SDP_L_FLOAT;
        end else if (pending) begin
          link_next.req_seen = l_req_tgl;
          link_next.step = SDP_FIRST_STEP;
          link_next.state = SDP_L_ACCESS;
        end
      end
      SDP_L_ACCESS: begin
        // hold requests wait here until the access ends
        link_next.cs_n = '1;
        link_next.cs_n[core_reg.space] = 1'b0;
        link_next.strobes = enc_strobes;
        link_next.lane_n = is_write ? core_reg.ben_n : '0;
        link_next.addr = core_reg.addr;
        if (is_rw) begin
          link_next.addr[SDP_COL_W-1:0] = col_addr;
        end
        if (core_reg.op == SDP_OP_PRE_ALL) begin
          link_next.addr[SDP_PRE_ALL_BIT] = 1'b1;
        end else if (core_reg.op == SDP_OP_PRE_BANK) begin
          link_next.addr[SDP_PRE_ALL_BIT] = 1'b0;
        end
        // one word per clock, no idle gap inside a burst
        link_next.data_oe = is_write;
        link_next.dout = core_reg.wdata[DATA_W * word_idx +: DATA_W];
        if (rd_capture) begin
          link_next.rdata[DATA_W * rd_idx +: DATA_W] = ext_data_bus_in;
        end
        if (access_end) begin
          link_next.state = SDP_L_IDLE;
          link_next.done_tgl = ~link_reg.done_tgl;
        end else begin
          link_next.step = 3'(link_reg.step + SDP_ONE_STEP);
        end
      end
      SDP_L_FLOAT: begin
        // grant follows the float by one clock, inside its two-clock window
        link_next.grant_n = 1'b0;
        link_next.state = SDP_L_HELD;
      end
      SDP_L_HELD: begin
        // new requests stay pending in the toggle until the bus is back
        if (hold_released) begin
          link_next.drive = 1'b1;
          link_next.state = SDP_L_RETAKE;
        end
      end
      SDP_L_RETAKE: begin
        // grant rises one clock after the bus is driven again
        link_next.grant_n = 1'b1;
        link_next.state = SDP_L_IDLE;
      end
      default: link_next.state = SDP_L_IDLE;
    endcase
    // outside an access the selects and lanes are off and the strobes at no-operation;
    // keyed on the present state so the last step of an access still reaches the pins
    if (link_reg.state != SDP_L_ACCESS) begin
      link_next.cs_n = '1;
      link_next.lane_n = '1;
      link_next.strobes = SDP_CMD_NOP;
      link_next.data_oe = 1'b0;
    end
  end

  // reset reaches this domain through the synchroniser, two link clocks behind the core
  always_ff @(posedge memory_bus_clock) begin
    if (!l_rst_n) begin
      link_reg <= '0;
      link_reg.state <= SDP_L_IDLE;
      link_reg.drive <= 1'b1;
      link_reg.grant_n <= 1'b1;
      link_reg.cs_n <= '1;
      link_reg.lane_n <= '1;
      link_reg.strobes <= SDP_CMD_NOP;
    end else if (l_ce) begin
      link_reg <= link_next;
    end
  end

  // ==========================================================
  // pins
  // every pin is a link flop, so the pins follow the state by one clock
  assign bus_release_grant_n = link_reg.grant_n;
  assign ext_bus_oe = link_reg.drive;
  assign ext_data_bus_oe = link_reg.data_oe;
  assign space_select_n = link_reg.cs_n;
  assign byte_lane_n = link_reg.lane_n;
  assign ext_address = link_reg.addr;
  assign ext_data_bus_out = link_reg.dout;
  assign output_row_shared_pin = link_reg.strobes[2];
  assign read_col_shared_pin = link_reg.strobes[1];
  assign write_shared_pin = link_reg.strobes[0];

endmodule

// ===== verilog/sdp_pkg.sv
// constants, encodings and timing figures shared by the memory port block
// assumes a core clock and a separate memory bus clock that paces the port pins
package sdp_pkg;

  // ==========================================================
  // widths
  localparam int SDP_ADDR_W = 20;
  localparam int SDP_DATA_W = 32;
  localparam int SDP_SPACES = 4;
  localparam int SDP_LANES = 4;
  localparam int SDP_BURST_LEN = 4;
  localparam int SDP_BURST_DATA_W = SDP_DATA_W * SDP_BURST_LEN;
  localparam int SDP_STEP_W = 3;

  // ==========================================================
  // sdram timing, in memory clock periods
  localparam logic [2:0] SDP_CAS_LAT = 3'h3;
  localparam logic [3:0] SDP_READ_STEPS = 4'h8;
  localparam logic [2:0] SDP_WRITE_STEPS = 3'h4;
  localparam logic [2:0] SDP_LAST_COL_STEP = 3'h3;
  localparam logic [2:0] SDP_FIRST_STEP = 3'h0;
  localparam logic [2:0] SDP_ONE_STEP = 3'h1;

  // release handshake figures, in memory clock periods (E)
  localparam int SDP_FLOAT_MIN_E = 2;
  localparam int SDP_GRANT_MAX_E = 2;
  localparam int SDP_RETAKE_MIN_E = 2;
  localparam int SDP_RETAKE_MAX_E = 7;
  localparam int SDP_REQ_HOLD_MIN_E = 1;

  // column address bit that selects all banks on a precharge
  localparam int SDP_PRE_ALL_BIT = 10;
  localparam int SDP_COL_W = 9;

  // ==========================================================
  // sdram command on {row, column, write} strobes, active low
  localparam logic [2:0] SDP_CMD_NOP = 3'h7;
  localparam logic [2:0] SDP_CMD_ACT = 3'h3;
  localparam logic [2:0] SDP_CMD_READ = 3'h5;
  localparam logic [2:0] SDP_CMD_WRITE = 3'h4;
  localparam logic [2:0] SDP_CMD_PRE = 3'h2;
  localparam logic [2:0] SDP_CMD_REF = 3'h1;
  localparam logic [2:0] SDP_CMD_MRS = 3'h0;

  // ==========================================================
  // user operations, burst orders and link states
  typedef enum logic [2:0] {
    SDP_OP_READ = 3'h0,
    SDP_OP_WRITE = 3'h1,
    SDP_OP_ACT = 3'h2,
    SDP_OP_PRE_ALL = 3'h3,
    SDP_OP_PRE_BANK = 3'h4,
    SDP_OP_REFRESH = 3'h5,
    SDP_OP_MODE_SET = 3'h6
  } sdp_op_e;

  typedef enum logic [1:0] {
    SDP_BT_INCR = 2'h0,
    SDP_BT_DECR = 2'h1,
    SDP_BT_RAND = 2'h2
  } sdp_burst_e;

  typedef enum logic [2:0] {
    SDP_L_IDLE = 3'h0,
    SDP_L_ACCESS = 3'h1,
    SDP_L_FLOAT = 3'h2,
    SDP_L_HELD = 3'h3,
    SDP_L_RETAKE = 3'h4
  } sdp_link_state_e;

endpackage

// ===== verilog/sdp_sync.sv
// two flip-flop synchroniser for a group of independent levels
// assumes each bit is a level that stays put for several destination clocks
`timescale 1ns/1ps
module sdp_sync #(
  parameter int W = 1
) (
  input wire logic clk, // destination clock
  input wire logic [W-1:0] d, // level from another domain
  output logic [W-1:0] q // synchronised level
);
  logic [W-1:0] meta_reg;

  // no reset: the first stage must feed only the second
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q <= meta_reg;
  end
endmodule

// ===== verilog/sdp_cmd_enc.sv
// maps an operation and burst step to the three sdram strobes
// assumes the caller registers the result before it reaches the pins
`timescale 1ns/1ps
module sdp_cmd_enc
  import sdp_pkg::*;
(
  input wire logic [2:0] op, // operation being run
  input wire logic col_cycle, // a command is due in this step
  output logic [2:0] strobes // {row, column, write}, active low
);
  always_comb begin
    strobes = SDP_CMD_NOP;
    if (col_cycle) begin
      case (op)
        SDP_OP_READ: strobes = SDP_CMD_READ;
        SDP_OP_WRITE: strobes = SDP_CMD_WRITE;
        SDP_OP_ACT: strobes = SDP_CMD_ACT;
        SDP_OP_PRE_ALL: strobes = SDP_CMD_PRE;
        SDP_OP_PRE_BANK: strobes = SDP_CMD_PRE;
        SDP_OP_REFRESH: strobes = SDP_CMD_REF;
        SDP_OP_MODE_SET: strobes = SDP_CMD_MRS;
        default: strobes = SDP_CMD_NOP;
      endcase
    end
  end
endmodule

// ===== bench/sdp_port_sva.sv
// checker for the release handshake and pin framing of the memory port
// assumes it is bound to sdp_port; every property runs on the memory clock
`timescale 1ns/1ps
module sdp_port_sva
  import sdp_pkg::*;
(
  input wire logic memory_bus_clock, // memory clock
  input wire logic rst_n, // reset, active low
  input wire logic release_inhibit, // grant blocker
  input wire logic bus_release_req_n, // release request
  input wire logic bus_release_grant_n, // release grant
  input wire logic ext_bus_oe, // bus drive enable
  input wire logic ext_data_bus_oe, // data drive enable
  input wire logic [SDP_SPACES-1:0] space_select_n, // selects
  input wire logic read_col_shared_pin, // column strobe
  input wire logic write_shared_pin, // write strobe
  input wire logic output_row_shared_pin // row strobe
);
  logic [2:0] cmd;
  assign cmd = {output_row_shared_pin, read_col_shared_pin, write_shared_pin};
  default clocking cb @(posedge memory_bus_clock); endclocking
  default disable iff (!rst_n);
  // ==========
  // release handshake
  a_float_late: assert property ($fell(bus_release_req_n) |-> ext_bus_oe [*2])
    else $error("bus floated too early");
  a_grant_low: assert property ($fell(ext_bus_oe) |-> ##[0:2] !bus_release_grant_n)
    else $error("grant late after float");
  a_retake_window: assert property ($rose(bus_release_req_n) && !ext_bus_oe |->
    !ext_bus_oe [*2] ##[1:6] ext_bus_oe)
    else $error("bus retaken outside window");
  a_grant_high: assert property ($rose(ext_bus_oe) |-> ##[0:2] bus_release_grant_n)
    else $error("grant not raised after retake");
  a_access_driven: assert property (space_select_n != 4'hf |-> ext_bus_oe)
    else $error("access while bus floated");
  a_inhibit_holds: assert property (release_inhibit [*4] ##0 bus_release_grant_n |=>
    bus_release_grant_n)
    else $error("grant under inhibit");
  a_float_all: assert property (!ext_bus_oe |-> !ext_data_bus_oe)
    else $error("data driven while floated");
  // ==========
  // burst framing
  a_write_flow: assert property ($rose(ext_data_bus_oe) |-> ext_data_bus_oe [*4] ##1 !ext_data_bus_oe)
    else $error("write data not four contiguous words");
  a_write_strobes: assert property (cmd == SDP_CMD_WRITE |-> ext_data_bus_oe)
    else $error("write command without data");
  c_grant: cover property ($fell(bus_release_grant_n));
  c_write: cover property ($rose(ext_data_bus_oe));
  c_read: cover property (cmd == SDP_CMD_READ);
endmodule
bind sdp_port sdp_port_sva i_sdp_port_sva (.memory_bus_clock(memory_bus_clock), .rst_n(rst_n),
  .release_inhibit(release_inhibit), .bus_release_req_n(bus_release_req_n),
  .bus_release_grant_n(bus_release_grant_n), .ext_bus_oe(ext_bus_oe), .ext_data_bus_oe(ext_data_bus_oe),
  .space_select_n(space_select_n), .read_col_shared_pin(read_col_shared_pin),
  .write_shared_pin(write_shared_pin), .output_row_shared_pin(output_row_shared_pin));

// ===== bench/sdp_mem_model.sv
// sdram model: one burst counter, column latency three, 512 words
// assumes strobes, address and data are sampled on the rising memory clock
`timescale 1ns/1ps
module sdp_mem_model
  import sdp_pkg::*;
(
  input wire logic clk, // memory clock
  input wire logic [2:0] cmd, // {row, column, write} strobes
  input wire logic [19:0] addr, // address pins
  input wire logic [31:0] dout, // write data from the port
  input wire logic doe, // port drives data
  output logic [31:0] din, // read data to the port
  output logic [7:0] ncol, // column commands seen
  output logic [2:0] lcmd, // last command other than nop
  output logic la10 // address bit 10 of that command
);
  logic [31:0] mem [512];
  logic [8:0] col = 9'h0, c1 = 9'h0, c2 = 9'h0, cur;
  logic [1:0] left = 2'h0;
  logic v1 = 1'b0, v2 = 1'b0, iscol, act;
  assign iscol = cmd == SDP_CMD_READ || cmd == SDP_CMD_WRITE;
  assign act = iscol || left != 2'h0;
  assign cur = iscol ? addr[8:0] : col + 9'h1;
  initial begin
    din = 32'h0;
    ncol = 8'h0;
    lcmd = SDP_CMD_NOP;
    la10 = 1'b0;
    for (int i = 0; i < 512; i++) mem[i] = {16'ha5c3, 7'h00, 9'(i)};
  end
  // a new column command cuts a running burst short, as a real part does
  always @(posedge clk) begin
    if (iscol) begin
      left <= 2'h3;
      ncol <= ncol + 8'h1;
    end else if (left != 2'h0) left <= left - 2'h1;
    if (act) col <= cur;
    if (cmd != SDP_CMD_NOP) begin
      lcmd <= cmd;
      la10 <= addr[SDP_PRE_ALL_BIT];
    end
    if (act && doe) mem[cur] <= dout;
    v1 <= act && !doe;
    c1 <= cur;
    v2 <= v1;
    c2 <= c1;
    // undriven bus toggles so a stale word never reads as good data
    din <= v2 ? mem[c2] : ~din;
  end
endmodule

// ===== bench/testbench.sv
// scenario testbench for the memory port against the sdram model
// assumes sdp_pkg, the design, the model and the bound checker are compiled first
`timescale 1ns/1ps
module testbench;
  import sdp_pkg::*;
  logic core_clk = 0, mclk = 0, rst_n = 0, req_valid = 0, inh = 0, hreq_n = 1;
  logic [2:0] op = 0, lcmd;
  logic [1:0] bt = 0;
  logic [7:0] ord = 0, ncol;
  logic [19:0] addr = 0, ea;
  logic [127:0] wdata = 0, rdata;
  logic ready, rvalid, away, grant_n, oe, doe, rs, cs, ws, la10;
  logic [3:0] sel_n, lane_n;
  logic [31:0] dout, din;
  int bad_count = 0, n_checks = 0, cyc = 0, nresp = 0;
  initial forever #5 core_clk = ~core_clk;
  // odd offset keeps memory clock edges off core edges
  initial begin
    #2.5;
    forever #16 mclk = ~mclk;
  end
  sdp_port i_sdp_port (.core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .req_valid(req_valid), .req_ready(ready),
    .req_op(op), .req_burst(bt), .req_order(ord), .req_addr(addr), .req_space(2'h1), .req_byte_en_n(4'h0),
    .req_wdata(wdata), .resp_valid(rvalid), .resp_rdata(rdata), .bus_away(away), .release_inhibit(inh),
    .memory_bus_clock(mclk), .bus_release_req_n(hreq_n), .bus_release_grant_n(grant_n), .ext_bus_oe(oe),
    .space_select_n(sel_n), .byte_lane_n(lane_n), .ext_address(ea), .ext_data_bus_out(dout),
    .ext_data_bus_oe(doe), .ext_data_bus_in(din), .read_col_shared_pin(cs), .write_shared_pin(ws),
    .output_row_shared_pin(rs));
  sdp_mem_model i_sdp_mem_model (.clk(mclk), .cmd({rs, cs, ws}), .addr(ea), .dout(dout), .doe(doe),
    .din(din), .ncol(ncol), .lcmd(lcmd), .la10(la10));
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (rvalid === 1'b1) nresp <= nresp + 1;
    if (cyc == 6000) begin
      bad_count++;
      end_of_test();
    end
  end
  // ==========
  // shared tasks
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  function automatic logic [31:0] wd(input logic [8:0] c);
    return {16'ha5c3, 7'h00, c};
  endfunction
  task automatic run(input logic [2:0] o, input logic [1:0] b, input logic [7:0] r, input logic [19:0] a);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    op <= o;
    bt <= b;
    ord <= r;
    addr <= a;
    req_valid <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
  endtask
  task automatic wait_resp;
    int n;
    n = 0;
    while (rvalid !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    chk(rvalid, 1'b1, "no response");
  endtask
  // ==========
  // scenarios
  task automatic t_ops;
    logic [2:0] ops [5] = '{SDP_OP_ACT, SDP_OP_PRE_ALL, SDP_OP_PRE_BANK, SDP_OP_REFRESH, SDP_OP_MODE_SET};
    logic [2:0] cmds [5] = '{SDP_CMD_ACT, SDP_CMD_PRE, SDP_CMD_PRE, SDP_CMD_REF, SDP_CMD_MRS};
    for (int i = 0; i < 5; i++) begin
      run(ops[i], SDP_BT_INCR, 8'h0, 20'h00123);
      wait_resp;
      // the done toggle can reach the core before the model has sampled the command
      repeat (4) @(posedge core_clk);
      chk(lcmd, cmds[i], "command code");
      if (i == 1 || i == 2) chk(la10, i == 1, "precharge bank bit");
    end
    $display("ops test done");
  endtask
  task automatic t_read(input logic [1:0] b, input logic [8:0] c, input logic [7:0] r);
    logic [127:0] e;
    logic [7:0] n0;
    logic [8:0] k;
    for (int i = 0; i < 4; i++) begin
      if (b == SDP_BT_INCR) k = c + 9'(i);
      else if (b == SDP_BT_DECR) k = c - 9'(i);
      else k = {c[8:2], r[2*i+:2]};
      e[32*i+:32] = wd(k);
    end
    n0 = ncol;
    run(SDP_OP_READ, b, r, {11'h0, c});
    wait_resp;
    chk(rdata, e, "read words");
    chk(8'(ncol - n0), (b == SDP_BT_INCR) ? 8'h1 : 8'h4, "column commands");
    $display("read test done");
  endtask
  task automatic t_write;
    logic [127:0] w;
    w = 128'h44444444_33333333_22222222_11111111;
    wdata <= w;
    run(SDP_OP_WRITE, SDP_BT_DECR, 8'h0, 20'h00043);
    wait_resp;
    run(SDP_OP_READ, SDP_BT_INCR, 8'h0, 20'h00040);
    wait_resp;
    chk(rdata, {w[31:0], w[63:32], w[95:64], w[127:96]}, "decrementing write");
    $display("write test done");
  endtask
  task automatic t_hold;
    int n, r0;
    run(SDP_OP_READ, SDP_BT_INCR, 8'h0, 20'h00008);
    n = 0;
    while (sel_n === 4'hf && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    chk({sel_n, lane_n}, 8'hd0, "select and lanes in a read");
    hreq_n <= 1'b0;
    wait_resp;
    chk(rdata[31:0], wd(9'h008), "access before grant");
    n = 0;
    while (grant_n !== 1'b0 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    chk({grant_n, oe, doe}, 3'b000, "bus floated at grant");
    r0 = nresp;
    run(SDP_OP_READ, SDP_BT_INCR, 8'h0, 20'h0000c);
    repeat (40) @(posedge core_clk);
    chk({away, 1'(nresp == r0)}, 2'b11, "access while away");
    hreq_n <= 1'b1;
    wait_resp;
    chk({rdata[31:0], grant_n, oe}, {wd(9'h00c), 2'b11}, "held access after retake");
    $display("hold test done");
  endtask
  task automatic t_inhibit;
    inh <= 1'b1;
    repeat (4) @(posedge core_clk);
    hreq_n <= 1'b0;
    repeat (60) @(posedge core_clk);
    chk({grant_n, oe}, 2'b11, "grant under inhibit");
    hreq_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    inh <= 1'b0;
    repeat (10) @(posedge core_clk);
    $display("inhibit test done");
  endtask
  // reset spans several memory clocks so the link side sees it too
  initial begin
    repeat (14) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk({grant_n, oe, doe}, 3'b110, "idle bus");
    t_ops();
    t_read(SDP_BT_INCR, 9'h010, 8'h0);
    t_read(SDP_BT_DECR, 9'h01f, 8'h0);
    t_read(SDP_BT_RAND, 9'h024, 8'h72);
    t_write();
    t_hold();
    t_inhibit();
    end_of_test();
  end
endmodule
